// ==== src/srap_pkg.sv ====
package srap_pkg;
  localparam int SRAP_DG_BITS = 40;
  localparam int SRAP_DATA_BITS = 32;
  localparam int SRAP_ADDR_BITS = 7;
  localparam int SRAP_DIR_POS = 39;
  localparam int SRAP_CNT_W = 6;
  localparam logic [5:0] SRAP_CNT_FULL = 6'h28;
  localparam logic [7:0] SRAP_STATUS_RST = 8'h01;
  localparam logic [31:0] SRAP_WORD_RST = 32'h0000_0000;
  localparam int SRAP_STOP_BIT = 0;
  localparam int SRAP_VREACH_BIT = 8;
  localparam int SRAP_ST_STOP2 = 6;
  localparam int SRAP_ST_STOP1 = 5;
  localparam int SRAP_ST_VR2 = 4;
  localparam int SRAP_ST_VR1 = 3;

  typedef struct packed {
    logic access_direction_bit;
    logic [6:0] addr;
    logic [31:0] data;
  } srap_cmd_t;

  typedef struct packed {
    logic [31:0] axis_one_ramp_status;
    logic [31:0] axis_two_ramp_status;
    logic [2:0] global_status_reg;
  } srap_stat_in_t;

  typedef enum logic [2:0] {
    SRAP_IDLE = 3'b001,
    SRAP_SHIFT = 3'b010,
    SRAP_DONE = 3'b100
  } srap_state_t;
endpackage

// ==== src/srap_port.sv ====
`timescale 1ns/1ps
`default_nettype none
module srap_port
  import srap_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic bus_clock,
  input wire logic chip_select_low,
  input wire logic serial_in_line,
  output logic serial_out_line,
  input wire srap_pkg::srap_stat_in_t stat_in,
  output srap_pkg::srap_cmd_t cmd_out,
  output logic cmd_valid,
  output logic [6:0] read_addr,
  input wire logic [31:0] read_data,
  output logic status_captured
);
  import srap_pkg::*;

  logic [2:0] sck_q;
  logic [2:0] cs_q;
  logic [1:0] sdi_q;
  logic [39:0] shreg_q;
  logic [5:0] cnt_q;
  logic [7:0] status_q;
  logic [31:0] reply_q;
  logic sdo_q;
  srap_cmd_t cmd_q;
  logic cmd_valid_q;
  logic [6:0] raddr_q;
  logic prev_read_q;
  logic load_q;
  srap_state_t state_q;

  // Synchronisers, third stage used for edge detection only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sck_q <= 3'h7;
      cs_q <= 3'h7;
      sdi_q <= 2'h0;
    end else begin
      sck_q <= {sck_q[1:0], bus_clock};
      cs_q <= {cs_q[1:0], chip_select_low};
      sdi_q <= {sdi_q[0], serial_in_line};
    end
  end

  wire sck_s = sck_q[1];
  wire cs_low = ~cs_q[1];
  wire sck_rise = sck_s & ~sck_q[2];
  wire sck_fall = ~sck_s & sck_q[2];
  wire cs_fall = ~cs_q[1] & cs_q[2];
  wire cs_rise = cs_q[1] & ~cs_q[2];
  wire full = (cnt_q == SRAP_CNT_FULL);
  wire [7:0] status_now = {1'b0,
    stat_in.axis_two_ramp_status[SRAP_STOP_BIT],
    stat_in.axis_one_ramp_status[SRAP_STOP_BIT],
    stat_in.axis_two_ramp_status[SRAP_VREACH_BIT],
    stat_in.axis_one_ramp_status[SRAP_VREACH_BIT],
    stat_in.global_status_reg};
  wire srap_cmd_t rx_cmd = srap_cmd_t'(shreg_q);
  wire rx_write = shreg_q[SRAP_DIR_POS];
  wire frame_end = (state_q == SRAP_SHIFT) && cs_rise && full;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q <= SRAP_IDLE;
    end else begin
      case (state_q)
        SRAP_IDLE: if (cs_fall) state_q <= SRAP_SHIFT;
        SRAP_SHIFT: if (cs_rise) state_q <= SRAP_DONE;
        SRAP_DONE: state_q <= SRAP_IDLE;
        default: state_q <= SRAP_IDLE;
      endcase
    end
  end

  // Shift register: rising edge samples, falling edge drives
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shreg_q <= 40'h00_0000_0000;
      cnt_q <= 6'h00;
      sdo_q <= 1'b0;
    end else if (cs_fall) begin
      shreg_q <= {status_q, reply_q};
      cnt_q <= 6'h00;
      sdo_q <= status_q[7];
    end else if (cs_low && sck_rise) begin
      shreg_q <= {shreg_q[38:0], sdi_q[1]};
      if (!full) cnt_q <= cnt_q + 6'h01;
    end else if (cs_low && sck_fall) begin
      sdo_q <= shreg_q[39];
    end
  end

  // Command latch on select rise ending a frame of 40 or more bits (bit count saturated at 40)
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cmd_q <= srap_cmd_t'({8'h00, SRAP_WORD_RST});
      cmd_valid_q <= 1'b0;
      raddr_q <= 7'h00;
      prev_read_q <= 1'b0;
      reply_q <= SRAP_WORD_RST;
      status_q <= SRAP_STATUS_RST;
      load_q <= 1'b0;
    end else begin
      cmd_valid_q <= 1'b0;
      load_q <= 1'b0;
      if (frame_end) begin
        load_q <= 1'b1;
        status_q <= status_now;
        if (rx_write) begin
          cmd_q <= rx_cmd;
          cmd_valid_q <= 1'b1;
          reply_q <= rx_cmd.data;
          prev_read_q <= 1'b0;
        end else begin
          raddr_q <= rx_cmd.addr;
          prev_read_q <= 1'b1;
        end
      end
      if (load_q && prev_read_q) begin
        reply_q <= read_data;
      end
    end
  end

  assign serial_out_line = sdo_q;
  assign cmd_out = cmd_q;
  assign cmd_valid = cmd_valid_q;
  assign read_addr = raddr_q;
  assign status_captured = load_q;

  property p_write_echo;
    @(posedge clk) disable iff (rst)
      (state_q == SRAP_SHIFT && cs_rise && full && rx_write)
      |=> cmd_valid && reply_q == $past(shreg_q[31:0]);
  endproperty
  a_write_echo: assert property (p_write_echo)
    else $error("write not echoed");

  property p_read_no_write;
    @(posedge clk) disable iff (rst)
      (state_q == SRAP_SHIFT && cs_rise && !rx_write) |=> !cmd_valid;
  endproperty
  a_read_no_write: assert property (p_read_no_write)
    else $error("read issued a write");

  property p_short_discard;
    @(posedge clk) disable iff (rst)
      (state_q == SRAP_SHIFT && cs_rise && !full)
      |=> (!cmd_valid && !status_captured && $stable(status_q)
        && $stable(reply_q)) ##1 $stable(reply_q);
  endproperty
  a_short_discard: assert property (p_short_discard)
    else $error("short frame acted on");

  property p_status_top;
    @(posedge clk) disable iff (rst)
      cs_fall |=> shreg_q[39:32] == status_q && !status_q[7];
  endproperty
  a_status_top: assert property (p_status_top)
    else $error("status byte not loaded");

  sequence s_read_done;
    state_q == SRAP_SHIFT && cs_rise && full && !rx_write;
  endsequence
  property p_read_reply;
    @(posedge clk) disable iff (rst)
      s_read_done ##1 (state_q == SRAP_DONE)
      |=> reply_q == $past(read_data);
  endproperty
  a_read_reply: assert property (p_read_reply)
    else $error("read reply wrong");

  property p_status_capture;
    @(posedge clk) disable iff (rst)
      (state_q == SRAP_SHIFT && cs_rise && full)
      |=> status_q == $past(status_now);
  endproperty
  a_status_capture: assert property (p_status_capture)
    else $error("status not captured");

  property p_count_sat;
    @(posedge clk) disable iff (rst) cnt_q <= SRAP_CNT_FULL;
  endproperty
  a_count_sat: assert property (p_count_sat)
    else $error("bit count overflow");

  property p_sdo_hold;
    @(posedge clk) disable iff (rst)
      (cs_low && !sck_fall && !cs_fall) |=> $stable(serial_out_line);
  endproperty
  a_sdo_hold: assert property (p_sdo_hold)
    else $error("output moved off falling edge");

  property p_count_clear;
    @(posedge clk) disable iff (rst) cs_fall |=> cnt_q == 6'h00;
  endproperty
  a_count_clear: assert property (p_count_clear)
    else $error("bit count not cleared");

  property p_count_step;
    @(posedge clk) disable iff (rst)
      (cs_low && sck_rise && !cs_fall && !full)
      |=> cnt_q == $past(cnt_q) + 6'h01;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("bit count did not advance");

  property p_shift_in;
    @(posedge clk) disable iff (rst)
      (cs_low && sck_rise && !cs_fall)
      |=> shreg_q == {$past(shreg_q[38:0]), $past(sdi_q[1])};
  endproperty
  a_shift_in: assert property (p_shift_in)
    else $error("input bit not shifted in");

  property p_sdo_follow;
    @(posedge clk) disable iff (rst)
      (cs_low && sck_fall && !cs_fall)
      |=> serial_out_line == $past(shreg_q[39]);
  endproperty
  a_sdo_follow: assert property (p_sdo_follow)
    else $error("output not taken from shift register");

  property p_sdo_first;
    @(posedge clk) disable iff (rst) cs_fall |=> !serial_out_line;
  endproperty
  a_sdo_first: assert property (p_sdo_first)
    else $error("first reply bit not zero");

  property p_cmd_stable;
    @(posedge clk) disable iff (rst)
      !(frame_end && rx_write)
      |=> $stable(cmd_out) && !cmd_valid;
  endproperty
  a_cmd_stable: assert property (p_cmd_stable)
    else $error("command changed without a write");

  property p_raddr_stable;
    @(posedge clk) disable iff (rst)
      !(frame_end && !rx_write)
      |=> $stable(read_addr);
  endproperty
  a_raddr_stable: assert property (p_raddr_stable)
    else $error("read address changed without a read");

  property p_read_capture;
    @(posedge clk) disable iff (rst)
      (frame_end && !rx_write)
      |=> read_addr == $past(shreg_q[38:32]);
  endproperty
  a_read_capture: assert property (p_read_capture)
    else $error("read address not captured");

  property p_capture_flag;
    @(posedge clk) disable iff (rst) frame_end |=> status_captured;
  endproperty
  a_capture_flag: assert property (p_capture_flag)
    else $error("capture pulse missing");

  property p_status_hold;
    @(posedge clk) disable iff (rst) !frame_end |=> $stable(status_q);
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("status changed between accesses");

  property p_stop_map;
    @(posedge clk) disable iff (rst)
      frame_end |=> !status_q[7]
        && status_q[SRAP_ST_STOP2] ==
          $past(stat_in.axis_two_ramp_status[SRAP_STOP_BIT])
        && status_q[SRAP_ST_STOP1] ==
          $past(stat_in.axis_one_ramp_status[SRAP_STOP_BIT]);
  endproperty
  a_stop_map: assert property (p_stop_map)
    else $error("stop switch status bits wrong");

  property p_speed_map;
    @(posedge clk) disable iff (rst)
      frame_end |=> status_q[SRAP_ST_VR2] ==
          $past(stat_in.axis_two_ramp_status[SRAP_VREACH_BIT])
        && status_q[SRAP_ST_VR1] ==
          $past(stat_in.axis_one_ramp_status[SRAP_VREACH_BIT]);
  endproperty
  a_speed_map: assert property (p_speed_map)
    else $error("speed reached status bits wrong");

  property p_fault_map;
    @(posedge clk) disable iff (rst)
      frame_end
      |=> status_q[2:1] == $past(stat_in.global_status_reg[2:1]);
  endproperty
  a_fault_map: assert property (p_fault_map)
    else $error("driver fault status bits wrong");

  property p_reset_map;
    @(posedge clk) disable iff (rst)
      frame_end
      |=> status_q[0] == $past(stat_in.global_status_reg[0]);
  endproperty
  a_reset_map: assert property (p_reset_map)
    else $error("reset flag status bit wrong");
endmodule
`default_nettype wire

// ==== bench/srap_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module srap_host (
  input wire logic clk,
  output logic bus_clock,
  output logic chip_select_low,
  output logic serial_in_line,
  input wire logic serial_out_line,
  output logic [47:0] rx
);
  event done;
  initial begin
    bus_clock = 1'b1;
    chip_select_low = 1'b1;
    serial_in_line = 1'b0;
    rx = '0;
  end
  // Half period of 8 clk, link far below clk/2
  task automatic half;
    repeat (8) @(posedge clk);
    #1;
  endtask
  task automatic xfer(input logic [47:0] v, input int n);
    rx = '0;
    chip_select_low = 1'b0;
    half();
    for (int i = n - 1; i >= 0; i--) begin
      bus_clock = 1'b0;
      serial_in_line = v[i];
      half();
      bus_clock = 1'b1;
      rx = {rx[46:0], serial_out_line};
      half();
    end
    chip_select_low = 1'b1;
    serial_in_line = ~serial_in_line;
    half();
    ->done;
    @(posedge clk);
    #1;
  endtask
endmodule
`default_nettype wire

// ==== bench/srap_port_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module srap_port_bench;
  import srap_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic bus_clock, chip_select_low, serial_in_line, serial_out_line;
  logic cmd_valid, status_captured;
  logic [6:0] read_addr;
  logic [31:0] read_data;
  logic [47:0] rx, e, v;
  srap_stat_in_t stat_in = '0;
  srap_cmd_t cmd_out;
  srap_cmd_t prev = '0;
  logic first = 1'b1;
  logic [7:0] st_cur = 8'h00;
  logic [47:0] rq[$];
  srap_cmd_t cq[$];
  logic [6:0] ra_cur = 7'h00;
  logic [6:0] ea;
  logic [6:0] aq[$];
  int mismatches = 0;
  int num_checks = 0;
  always #2.5 clk = ~clk;
  function automatic logic [31:0] mem(input logic [6:0] a);
    return {a, ~a, 18'h2a5c3};
  endfunction
  assign read_data = mem(read_addr);
  srap_port srap_port_inst (.clk(clk), .rst(rst), .bus_clock(bus_clock),
    .chip_select_low(chip_select_low), .serial_in_line(serial_in_line),
    .serial_out_line(serial_out_line), .stat_in(stat_in),
    .cmd_out(cmd_out), .cmd_valid(cmd_valid), .read_addr(read_addr),
    .read_data(read_data), .status_captured(status_captured));
  srap_host srap_host_inst (.clk(clk), .bus_clock(bus_clock),
    .chip_select_low(chip_select_low), .serial_in_line(serial_in_line),
    .serial_out_line(serial_out_line), .rx(rx));
  task automatic chk(input string n, input logic [47:0] s, ex);
    num_checks++;
    if (s !== ex) begin
      mismatches++;
      $display("MISMATCH %s exp %h seen %h", n, ex, s);
    end
  endtask
  task automatic wrap_up;
    $display("mismatches %0d checks %0d", mismatches, num_checks);
    if (mismatches == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial forever begin
    @(srap_host_inst.done);
    chk("reply", rx, rq.pop_front());
  end
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) begin
      e = cq.size() != 0 ? 48'(cq.pop_front()) : 48'hx;
      chk("cmd", 48'(cmd_out), e);
    end
    if (status_captured === 1'b1) begin
      ea = aq.size() != 0 ? aq.pop_front() : 7'hx;
      chk("raddr", 48'(read_addr), 48'(ea));
    end
  end
  task automatic frame(input srap_cmd_t c, input int n, input logic [7:0] x);
    logic [39:0] r;
    r = first ? {SRAP_STATUS_RST, SRAP_WORD_RST}
      : prev.access_direction_bit ? {st_cur, prev.data}
      : {st_cur, mem(prev.addr)};
    stat_in = srap_stat_in_t'({$urandom, $urandom, 3'($urandom)});
    v = n == 48 ? {x, c} : 48'(c >> (40 - n));
    rq.push_back(n == 48 ? {r, x} : 48'(r >> (40 - n)));
    if (n >= 40 && c.access_direction_bit) cq.push_back(c);
    if (n >= 40 && !c.access_direction_bit) ra_cur = c.addr;
    if (n >= 40) aq.push_back(ra_cur);
    srap_host_inst.xfer(v, n);
    if (n >= 40) begin
      prev = c;
      first = 1'b0;
      st_cur = {1'b0, stat_in.axis_two_ramp_status[0],
        stat_in.axis_one_ramp_status[0], stat_in.axis_two_ramp_status[8],
        stat_in.axis_one_ramp_status[8], stat_in.global_status_reg};
    end
  endtask
  initial begin
    void'($urandom(4650));
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    for (int i = 0; i < 14; i++) begin
      frame({i[1], 7'($urandom), $urandom},
        i == 6 ? 20 : i == 9 ? 48 : 40, 8'($urandom));
    end
    repeat (10) @(posedge clk);
    chk("left", 48'(rq.size() + cq.size() + aq.size()), 48'h0);
    wrap_up();
  end
  initial begin
    #150000;
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
